// file: hdl/ivm_pkg.sv
// Constants of the interrupt vector map: source indices and word addresses.
// Assumes a core that fetches from a word address on a taken vector.
// How it works
// - Any reset starts execution at word zero
// - External zero to one, external one thirteen
// - Pin change request goes to word two
// - Second timer: three, four, five, seventeen
// - Second timer fault goes to word eighteen
// - First timer: six, fourteen, fifteen, sixteen
// - Serial start seven, wrap eight, nonvolatile nine
// - Comparator to ten, converter done eleven
// - Watchdog time-out goes to word twelve
// - Never dispatch a disabled source, except one disabled in the same cycle the core takes it
package ivm_pkg;
  localparam int IVM_NUM_SRC = 18;
  localparam int IVM_IDX_W = 5;
  localparam int IVM_ADDR_W = 16;

  // Vector numbers, zero being reset
  localparam logic [4:0] IDX_RESET = 5'h00;
  localparam logic [4:0] IDX_EXT_ZERO = 5'h01;
  localparam logic [4:0] IDX_PIN_CHANGE = 5'h02;
  localparam logic [4:0] IDX_TB_MATCH_A = 5'h03;
  localparam logic [4:0] IDX_TB_MATCH_B = 5'h04;
  localparam logic [4:0] IDX_TB_OVERFLOW = 5'h05;
  localparam logic [4:0] IDX_TA_OVERFLOW = 5'h06;
  localparam logic [4:0] IDX_SER_START = 5'h07;
  localparam logic [4:0] IDX_SER_WRAP = 5'h08;
  localparam logic [4:0] IDX_NV_READY = 5'h09;
  localparam logic [4:0] IDX_COMPARATOR = 5'h0a;
  localparam logic [4:0] IDX_CONV_DONE = 5'h0b;
  localparam logic [4:0] IDX_WATCHDOG = 5'h0c;
  localparam logic [4:0] IDX_EXT_ONE = 5'h0d;
  localparam logic [4:0] IDX_TA_MATCH_A = 5'h0e;
  localparam logic [4:0] IDX_TA_MATCH_B = 5'h0f;
  localparam logic [4:0] IDX_TA_CAPTURE = 5'h10;
  localparam logic [4:0] IDX_TB_MATCH_D = 5'h11;
  localparam logic [4:0] IDX_TB_FAULT = 5'h12;

  // Program word addresses of the vectors
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] ADDR_EXT_ZERO = 16'h0001;
  localparam logic [15:0] ADDR_PIN_CHANGE = 16'h0002;
  localparam logic [15:0] ADDR_TB_MATCH_A = 16'h0003;
  localparam logic [15:0] ADDR_TB_MATCH_B = 16'h0004;
  localparam logic [15:0] ADDR_TB_OVERFLOW = 16'h0005;
  localparam logic [15:0] ADDR_TA_OVERFLOW = 16'h0006;
  localparam logic [15:0] ADDR_SER_START = 16'h0007;
  localparam logic [15:0] ADDR_SER_WRAP = 16'h0008;
  localparam logic [15:0] ADDR_NV_READY = 16'h0009;
  localparam logic [15:0] ADDR_COMPARATOR = 16'h000a;
  localparam logic [15:0] ADDR_CONV_DONE = 16'h000b;
  localparam logic [15:0] ADDR_WATCHDOG = 16'h000c;
  localparam logic [15:0] ADDR_EXT_ONE = 16'h000d;
  localparam logic [15:0] ADDR_TA_MATCH_A = 16'h000e;
  localparam logic [15:0] ADDR_TA_MATCH_B = 16'h000f;
  localparam logic [15:0] ADDR_TA_CAPTURE = 16'h0010;
  localparam logic [15:0] ADDR_TB_MATCH_D = 16'h0011;
  localparam logic [15:0] ADDR_TB_FAULT = 16'h0012;
endpackage : ivm_pkg

// file: hdl/ivm_pick.sv
// Lowest-number finder over the pending request vector.
// Assumes bit zero (reset) is never set by the caller.
`timescale 1ns/1ps
module ivm_pick #(
  parameter int NUM_SRC = ivm_pkg::IVM_NUM_SRC
) (
  // Masked pending requests, one bit per vector number
  input wire logic [NUM_SRC:0] pend,
  // Winner
  output logic found,
  output logic [4:0] win_idx
);
  // Scan downward so the lowest set bit is the last one kept
  always_comb begin
    found = 1'b0;
    win_idx = 5'h00;
    for (int i = NUM_SRC; i >= 1; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        win_idx = 5'(i);
      end
    end
  end
endmodule : ivm_pick

// file: hdl/ivm_lut.sv
// Fixed vector number to program word address table.
// Assumes indices above the last vector never reach it.
`timescale 1ns/1ps
module ivm_lut (
  // Vector number in
  input wire logic [4:0] idx,
  // Word address out
  output logic [15:0] addr
);
  // Constant table
  always_comb begin
    case (idx)
      ivm_pkg::IDX_EXT_ZERO: addr = ivm_pkg::ADDR_EXT_ZERO;
      ivm_pkg::IDX_PIN_CHANGE: addr = ivm_pkg::ADDR_PIN_CHANGE;
      ivm_pkg::IDX_TB_MATCH_A: addr = ivm_pkg::ADDR_TB_MATCH_A;
      ivm_pkg::IDX_TB_MATCH_B: addr = ivm_pkg::ADDR_TB_MATCH_B;
      ivm_pkg::IDX_TB_OVERFLOW: addr = ivm_pkg::ADDR_TB_OVERFLOW;
      ivm_pkg::IDX_TA_OVERFLOW: addr = ivm_pkg::ADDR_TA_OVERFLOW;
      ivm_pkg::IDX_SER_START: addr = ivm_pkg::ADDR_SER_START;
      ivm_pkg::IDX_SER_WRAP: addr = ivm_pkg::ADDR_SER_WRAP;
      ivm_pkg::IDX_NV_READY: addr = ivm_pkg::ADDR_NV_READY;
      ivm_pkg::IDX_COMPARATOR: addr = ivm_pkg::ADDR_COMPARATOR;
      ivm_pkg::IDX_CONV_DONE: addr = ivm_pkg::ADDR_CONV_DONE;
      ivm_pkg::IDX_WATCHDOG: addr = ivm_pkg::ADDR_WATCHDOG;
      ivm_pkg::IDX_EXT_ONE: addr = ivm_pkg::ADDR_EXT_ONE;
      ivm_pkg::IDX_TA_MATCH_A: addr = ivm_pkg::ADDR_TA_MATCH_A;
      ivm_pkg::IDX_TA_MATCH_B: addr = ivm_pkg::ADDR_TA_MATCH_B;
      ivm_pkg::IDX_TA_CAPTURE: addr = ivm_pkg::ADDR_TA_CAPTURE;
      ivm_pkg::IDX_TB_MATCH_D: addr = ivm_pkg::ADDR_TB_MATCH_D;
      ivm_pkg::IDX_TB_FAULT: addr = ivm_pkg::ADDR_TB_FAULT;
      default: addr = ivm_pkg::ADDR_RESET;
    endcase
  end
endmodule : ivm_lut

// file: hdl/ivm_map.sv
// Interrupt vector map: picks one enabled request and offers its vector
// address to the core fetch logic; acknowledges the source when taken.
// Assumes request lines come from peripheral logic on ref_clk, held high
// until acknowledged, and a core that pulses core_accept to take a vector.
`timescale 1ns/1ps
module ivm_map #(
  parameter int NUM_SRC = ivm_pkg::IVM_NUM_SRC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Request lines from the sources
  input wire logic ext_request_zero,
  input wire logic pin_change_request,
  input wire logic timer_b_match_a,
  input wire logic timer_b_match_b,
  input wire logic timer_b_overflow,
  input wire logic timer_a_overflow,
  input wire logic serial_if_start_seen,
  input wire logic serial_if_counter_wrap,
  input wire logic nv_data_ready,
  input wire logic comparator_event,
  input wire logic converter_done,
  input wire logic watchdog_timeout,
  input wire logic ext_request_one,
  input wire logic timer_a_match_a,
  input wire logic timer_a_match_b,
  input wire logic timer_a_capture_event,
  input wire logic timer_b_match_d,
  input wire logic timer_b_fault,
  // Enables: global, and one per vector number (bit 0 unused)
  input wire logic global_int_enable,
  input wire logic [NUM_SRC:0] src_enable,
  // Core side
  input wire logic core_accept,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  output logic [4:0] vector_num,
  // Acknowledge to the sources, one per vector number (bit 0 unused)
  output logic [NUM_SRC:0] src_ack
);
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_OFFER} ivm_state_t;

  ivm_state_t state;
  ivm_state_t next_state;
  logic next_vector_valid;
  logic [15:0] next_vector_addr;
  logic [4:0] next_vector_num;
  logic [NUM_SRC:0] next_src_ack;
  logic [NUM_SRC:0] req;
  logic [NUM_SRC:0] pend;
  logic found;
  logic [4:0] win_idx;
  logic [15:0] win_addr;

  // Gather request lines by vector number
  always_comb begin
    req = '0;
    req[ivm_pkg::IDX_EXT_ZERO] = ext_request_zero;
    req[ivm_pkg::IDX_PIN_CHANGE] = pin_change_request;
    req[ivm_pkg::IDX_TB_MATCH_A] = timer_b_match_a;
    req[ivm_pkg::IDX_TB_MATCH_B] = timer_b_match_b;
    req[ivm_pkg::IDX_TB_OVERFLOW] = timer_b_overflow;
    req[ivm_pkg::IDX_TA_OVERFLOW] = timer_a_overflow;
    req[ivm_pkg::IDX_SER_START] = serial_if_start_seen;
    req[ivm_pkg::IDX_SER_WRAP] = serial_if_counter_wrap;
    req[ivm_pkg::IDX_NV_READY] = nv_data_ready;
    req[ivm_pkg::IDX_COMPARATOR] = comparator_event;
    req[ivm_pkg::IDX_CONV_DONE] = converter_done;
    req[ivm_pkg::IDX_WATCHDOG] = watchdog_timeout;
    req[ivm_pkg::IDX_EXT_ONE] = ext_request_one;
    req[ivm_pkg::IDX_TA_MATCH_A] = timer_a_match_a;
    req[ivm_pkg::IDX_TA_MATCH_B] = timer_a_match_b;
    req[ivm_pkg::IDX_TA_CAPTURE] = timer_a_capture_event;
    req[ivm_pkg::IDX_TB_MATCH_D] = timer_b_match_d;
    req[ivm_pkg::IDX_TB_FAULT] = timer_b_fault;
  end

  // Only enabled sources count as pending; reset slot never pends
  always_comb begin
    pend = req & src_enable & {(NUM_SRC + 1){global_int_enable}};
    pend[0] = 1'b0;
  end

  // Lowest pending number and its address
  ivm_pick #(
    .NUM_SRC(NUM_SRC)
  ) u_pick (
    .pend(pend),
    .found(found),
    .win_idx(win_idx)
  );

  ivm_lut u_lut (
    .idx(win_idx),
    .addr(win_addr)
  );

  // Dispatch sequencing: boot vector, then offer and withdraw interrupts
  always_comb begin
    next_state = state;
    next_vector_valid = vector_valid;
    next_vector_addr = vector_addr;
    next_vector_num = vector_num;
    next_src_ack = '0;
    case (state)
      ST_BOOT: begin
        // Reset vector offered until the core takes it
        next_vector_valid = 1'b1;
        next_vector_addr = ivm_pkg::ADDR_RESET;
        next_vector_num = ivm_pkg::IDX_RESET;
        if (core_accept) begin
          next_state = ST_IDLE;
          next_vector_valid = 1'b0;
        end
      end
      ST_IDLE: begin
        if (found) begin
          next_state = ST_OFFER;
          next_vector_valid = 1'b1;
          next_vector_addr = win_addr;
          next_vector_num = win_idx;
        end
      end
      ST_OFFER: begin
        if (core_accept) begin
          // Taken: acknowledge the offered source, clearing its flag
          next_src_ack[vector_num] = 1'b1;
          next_state = ST_IDLE;
          next_vector_valid = 1'b0;
        end else if (!found) begin
          // Disabled or dropped before taken: withdraw the offer
          next_state = ST_IDLE;
          next_vector_valid = 1'b0;
        end else if (win_idx != vector_num) begin
          // A lower number arrived or the offered one went away
          next_vector_addr = win_addr;
          next_vector_num = win_idx;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_vector_valid = 1'b0;
      end
    endcase
  end

  // State and output registers; reset vector shows from reset on
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_BOOT;
      vector_valid <= 1'b1;
      vector_addr <= ivm_pkg::ADDR_RESET;
      vector_num <= ivm_pkg::IDX_RESET;
      src_ack <= '0;
    end else begin
      state <= next_state;
      vector_valid <= next_vector_valid;
      vector_addr <= next_vector_addr;
      vector_num <= next_vector_num;
      src_ack <= next_src_ack;
    end
  end

  // Checks
  logic [NUM_SRC:0] below_mask;
  always_comb begin
    below_mask = '0;
    for (int i = 0; i <= NUM_SRC; i++) begin
      if (5'(i) < win_idx) begin
        below_mask[i] = 1'b1;
      end
    end
  end

  // Reset and the boot offer
  a_reset_vector_zero: assert property (
    @(posedge ref_clk)
    $rose(resetn) |-> vector_valid && vector_addr == 16'h0000)
    else $error("reset vector not at word zero");
  a_boot_offer: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_BOOT
    |-> vector_valid && vector_num == 5'h00 && vector_addr == 16'h0000)
    else $error("boot state not offering word zero");
  a_boot_no_ack: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_BOOT && core_accept
    |=> state == ST_IDLE && !vector_valid && src_ack == '0)
    else $error("boot vector take misbehaved");

  // Fixed word addresses of the offered vectors
  a_ext_vectors: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    vector_valid && state == ST_OFFER &&
    (vector_num == 5'h01 || vector_num == 5'h0d)
    |-> vector_addr == (vector_num == 5'h01 ? 16'h0001 : 16'h000d))
    else $error("external request vector address wrong");
  a_addr_pairs_num: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    vector_valid |-> vector_addr == {11'h000, vector_num})
    else $error("vector address and number disagree");
  a_pin_change_vec: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_IDLE && found && win_idx == 5'h02
    |=> vector_valid && vector_addr == 16'h0002)
    else $error("pin change vector address wrong");
  a_timer_b_vecs: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_num inside {5'h03, 5'h04, 5'h05, 5'h11}
    |-> vector_addr == {11'h000, vector_num})
    else $error("second timer vector address wrong");
  a_fault_vector: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_num == 5'h12
    |-> vector_addr == 16'h0012)
    else $error("fault vector address wrong");
  a_table_end: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    vector_num <= 5'h12)
    else $error("vector number beyond the last entry");
  a_timer_a_vecs: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_num inside {5'h06, 5'h0e, 5'h0f, 5'h10}
    |-> vector_addr == {11'h000, vector_num})
    else $error("first timer vector address wrong");
  a_serial_nv_vecs: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_num inside {5'h07, 5'h08, 5'h09}
    |-> vector_addr == {11'h000, vector_num})
    else $error("serial or nonvolatile vector address wrong");
  a_analog_vecs: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_num inside {5'h0a, 5'h0b}
    |-> vector_addr == {11'h000, vector_num})
    else $error("comparator or converter vector address wrong");
  a_watchdog_vec: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_IDLE && found && win_idx == 5'h0c
    |=> vector_addr == 16'h000c)
    else $error("watchdog vector address wrong");

  // Only enabled pending sources are offered; others are withdrawn
  a_ack_enabled_only: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (src_ack != '0) |-> ($past(pend) & src_ack) == src_ack)
    else $error("acknowledge for a source that was not enabled");
  a_offer_needs_pend: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && vector_valid |-> $past(found))
    else $error("vector offered with nothing enabled pending");
  a_pend_gated: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    found |-> global_int_enable && src_enable[win_idx] && req[win_idx])
    else $error("disabled source counted as pending");
  a_idle_quiet: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_IDLE |-> !vector_valid)
    else $error("vector offered while idle");
  a_withdraw: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && !core_accept && !found
    |=> !vector_valid && src_ack == '0)
    else $error("offer not withdrawn after its source went away");
  a_valid_holds: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    vector_valid && !core_accept && found |=> vector_valid)
    else $error("offer dropped while still pending and not taken");

  // Taking a vector acknowledges exactly its source for one cycle
  a_take_acks: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && core_accept
    |=> !vector_valid && src_ack[vector_num])
    else $error("taken vector not acknowledged");
  a_ack_one_hot: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    src_ack != '0 |-> $onehot(src_ack) && !src_ack[0] && !vector_valid)
    else $error("acknowledge not a single interrupt source");
  a_ack_pulse: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    src_ack != '0 |=> src_ack == '0)
    else $error("acknowledge longer than one cycle");

  // Lowest pending number first, replaced live by a lower one
  a_lowest_first: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    found |-> (pend & below_mask) == '0 && pend[win_idx])
    else $error("winner is not the lowest pending number");
  a_offer_from_idle: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_IDLE && found
    |=> vector_valid && vector_num == $past(win_idx) &&
    vector_addr == {11'h000, $past(win_idx)})
    else $error("idle offer is not the lowest pending vector");
  a_replace_lower: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && !core_accept && found && win_idx < vector_num
    |=> vector_valid && vector_num == $past(win_idx))
    else $error("lower pending vector did not replace the offer");
  a_offer_kept: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    state == ST_OFFER && !core_accept && found && win_idx == vector_num
    |=> vector_valid && $stable(vector_num) && $stable(vector_addr))
    else $error("standing offer changed without cause");
endmodule : ivm_map

// file: tb/ivm_core_model.sv
// Core fetch model: takes each offered vector after a set wait.
// Assumes the map's handshake on ref_clk, core_accept as a pulse.
`timescale 1ns/1ps
module ivm_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Offer and acknowledges from the map
  input wire logic vector_valid,
  input wire logic [15:0] vector_addr,
  input wire logic [4:0] vector_num,
  input wire logic [18:0] src_ack,
  // Cycles to wait before taking an offer
  input wire logic [15:0] wait_cyc,
  // Take pulse and record of the last fetch
  output logic core_accept,
  output logic [15:0] fetch_addr,
  output logic [4:0] fetch_num,
  output logic [18:0] fetch_ack,
  output logic [15:0] fetch_cnt
);
  logic [15:0] wait_n = 16'h0000;
  logic took = 1'b0;
  initial core_accept = 1'b0;
  initial fetch_cnt = 16'h0000;
  // Take pulse off the falling edge once the wait is over
  always @(negedge ref_clk) begin
    core_accept <= resetn && vector_valid && !core_accept &&
                   wait_n >= wait_cyc;
  end
  // Wait count, fetch record, and the acknowledge one cycle on
  always @(posedge ref_clk) begin
    wait_n <= (resetn && vector_valid && !core_accept) ?
              wait_n + 16'h0001 : 16'h0000;
    took <= core_accept && vector_valid;
    if (core_accept && vector_valid) begin
      fetch_addr <= vector_addr;
      fetch_num <= vector_num;
      fetch_cnt <= fetch_cnt + 16'h0001;
    end
    if (took) begin
      fetch_ack <= src_ack;
    end
  end
endmodule : ivm_core_model

// file: tb/ivm_map_bench.sv
// Bench for the vector map, with a core model taking its offers.
// Assumes request levels are held until the map acknowledges them.
`timescale 1ns/1ps
module ivm_map_bench;
  // Expected word address of each vector number
  localparam logic [15:0] EXP_ADDR [0:18] = '{16'h0000, 16'h0001, 16'h0002,
    16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0009,
    16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h0010,
    16'h0011, 16'h0012};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic glb_en = 1'b0;
  logic [18:0] en = '0;
  logic [18:0] req = '0;
  logic [18:0] set_req = '0;
  logic [15:0] wait_cyc = 16'h0004;
  logic core_accept, vector_valid;
  logic [15:0] vector_addr, fetch_addr, fetch_cnt, n0;
  logic [4:0] vector_num, fetch_num;
  logic [18:0] src_ack, fetch_ack;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // Sources hold a request until its acknowledge is seen
  always @(negedge ref_clk) begin
    req <= (req & ~src_ack) | set_req;
    set_req <= '0;
  end
  ivm_map dut (
    .ref_clk(ref_clk), .resetn(resetn),
    .ext_request_zero(req[1]), .pin_change_request(req[2]),
    .timer_b_match_a(req[3]), .timer_b_match_b(req[4]),
    .timer_b_overflow(req[5]), .timer_a_overflow(req[6]),
    .serial_if_start_seen(req[7]), .serial_if_counter_wrap(req[8]),
    .nv_data_ready(req[9]), .comparator_event(req[10]),
    .converter_done(req[11]), .watchdog_timeout(req[12]),
    .ext_request_one(req[13]), .timer_a_match_a(req[14]),
    .timer_a_match_b(req[15]), .timer_a_capture_event(req[16]),
    .timer_b_match_d(req[17]), .timer_b_fault(req[18]),
    .global_int_enable(glb_en), .src_enable(en),
    .core_accept(core_accept), .vector_valid(vector_valid),
    .vector_addr(vector_addr), .vector_num(vector_num), .src_ack(src_ack)
  );
  ivm_core_model core (
    .ref_clk(ref_clk), .resetn(resetn), .vector_valid(vector_valid),
    .vector_addr(vector_addr), .vector_num(vector_num), .src_ack(src_ack),
    .wait_cyc(wait_cyc), .core_accept(core_accept),
    .fetch_addr(fetch_addr), .fetch_num(fetch_num),
    .fetch_ack(fetch_ack), .fetch_cnt(fetch_cnt)
  );
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Compare of addresses and counts
  task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  // Compare of flags, numbers and acknowledge masks
  task automatic chk_bits(string what, logic [18:0] exp, logic [18:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits
  task automatic idle(int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  // Raise request bits, applied by the sources at the next falling edge
  task automatic raise(logic [18:0] m);
    @(posedge ref_clk);
    #1 set_req = m;
    @(negedge ref_clk);
  endtask : raise
  // Wait, bounded, for the core to take one more vector
  task automatic wait_fetch();
    n0 = fetch_cnt;
    for (int i = 0; i < 60 && fetch_cnt == n0; i++) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    chk_word("fetch count", n0 + 16'h0001, fetch_cnt);
  endtask : wait_fetch
  task automatic t_boot();
    idle(5);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk_bits("boot valid", 19'h1, {18'h0, vector_valid});
    chk_word("boot addr", 16'h0000, vector_addr);
    wait_fetch();
    chk_word("boot fetch", 16'h0000, fetch_addr);
    chk_bits("boot ack", 19'h0, fetch_ack);
    $display("test boot done");
  endtask : t_boot
  task automatic t_table();
    wait_cyc = 16'h0000;
    glb_en = 1'b1;
    en = '1;
    for (int n = 1; n <= 18; n++) begin
      raise(19'h1 << n);
      wait_fetch();
      chk_word("addr", EXP_ADDR[n], fetch_addr);
      chk_bits("num", 19'(n), {14'h0, fetch_num});
      chk_bits("ack", 19'h1 << n, fetch_ack);
    end
    $display("test table done");
  endtask : t_table
  task automatic t_mask();
    glb_en = 1'b0;
    en = 19'h7efff;
    raise(19'h01008);
    idle(20);
    chk_bits("masked valid", 19'h0, {18'h0, vector_valid});
    glb_en = 1'b1;
    wait_fetch();
    chk_bits("global on", 19'h3, {14'h0, fetch_num});
    idle(20);
    chk_bits("disabled valid", 19'h0, {18'h0, vector_valid});
    en = '1;
    wait_fetch();
    chk_word("enabled addr", 16'h000c, fetch_addr);
    wait_cyc = 16'h0010;
    raise(19'h00400);
    idle(2);
    chk_bits("offer num", 19'h0a, {14'h0, vector_num});
    en = 19'h7fbff;
    idle(2);
    chk_bits("withdrawn valid", 19'h0, {18'h0, vector_valid});
    chk_bits("withdrawn ack", 19'h0, src_ack);
    en = '1;
    wait_fetch();
    chk_bits("offer again", 19'h0a, {14'h0, fetch_num});
    chk_bits("offer again ack", 19'h00400, fetch_ack);
    $display("test mask done");
  endtask : t_mask
  task automatic t_prio();
    logic [4:0] order [3] = '{5'h05, 5'h0d, 5'h12};
    wait_cyc = 16'h000a;
    raise(19'h40000);
    idle(2);
    chk_bits("first offer", 19'h12, {14'h0, vector_num});
    raise(19'h02020);
    idle(2);
    chk_word("replaced addr", 16'h0005, vector_addr);
    for (int k = 0; k < 3; k++) begin
      wait_fetch();
      chk_bits("order", {14'h0, order[k]}, {14'h0, fetch_num});
    end
    $display("test priority done");
  endtask : t_prio
  task automatic t_rereset();
    wait_cyc = 16'h0005;
    raise(19'h00080);
    idle(1);
    resetn = 1'b0;
    idle(2);
    chk_bits("reset valid", 19'h1, {18'h0, vector_valid});
    chk_word("reset addr", 16'h0000, vector_addr);
    chk_bits("reset ack", 19'h0, src_ack);
    resetn = 1'b1;
    wait_fetch();
    chk_word("boot again", 16'h0000, fetch_addr);
    wait_fetch();
    chk_word("held request", 16'h0007, fetch_addr);
    $display("test second reset done");
  endtask : t_rereset
  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 2000) begin
      error_cnt++;
      $display("timeout after %0d cycles", cycles);
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    t_boot();
    t_table();
    t_mask();
    t_prio();
    t_rereset();
    print_verdict();
  end
endmodule : ivm_map_bench
